// [hdl/scc_spindle_ctrl.sv]
// Spindle commutation decoder, mode control and current chopping logic
`timescale 1ns/10ps
module scc_spindle_ctrl
  import scc_pkg::*;
(
  input  wire logic               clk,                // 25 MHz clock
  input  wire logic               arst_n,             // Async reset, active low
  input  wire logic               phaseSelect1,       // Commutation select 1
  input  wire logic               phaseSelect2,       // Commutation select 2
  input  wire logic               phaseSelect3,       // Commutation select 3
  input  wire logic [1:0]         spindleModeLine,    // Encoded three-level mode
  input  wire logic               underVoltage,       // Supply below threshold
  input  wire logic               spindleCurrentCommand, // Current-command PWM
  input  wire logic [LEVEL_W-1:0] currentSense,       // Sampled coil current
  input  wire logic               bemfCompU,          // Back-EMF comparator U
  input  wire logic               bemfCompV,          // Back-EMF comparator V
  input  wire logic               bemfCompW,          // Back-EMF comparator W
  input  wire logic               inductionComp,      // Induction comparator
  output logic                    phaseUOutputHigh,   // U upper gate
  output logic                    phaseUOutputLow,    // U lower gate
  output logic                    phaseVOutputHigh,   // V upper gate
  output logic                    phaseVOutputLow,    // V lower gate
  output logic                    phaseWOutputHigh,   // W upper gate
  output logic                    phaseWOutputLow,    // W lower gate
  output logic                    bemfSenseU,         // Sense output U
  output logic                    bemfSenseV,         // Sense output V
  output logic                    bemfSenseWShared,   // Sense W or induction
  output logic                    upperLinearRegion,  // Upper gates resistive
  output logic                    offTimeActive,      // One-shot running
  output logic [LEVEL_W-1:0]      currentSetLevel,    // Measured set level
  output logic [2:0]              commutationStep,    // Registered select code
  output logic [2:0]              spindleMode         // One-hot active mode
);

  localparam scc_top_state_t TOP_RESET = '{mode: MODE_LINEAR, default: '0};

  scc_top_state_t         cur;
  scc_top_state_t         next_cur;
  logic [2:0]             selCode;
  logic [2:0][1:0]        baseDrive;
  logic                   commutating;
  logic                   oneShotFire;
  logic                   offActive;
  logic [LEVEL_W-1:0]     setLevel;

  assign selCode = {phaseSelect1, phaseSelect2, phaseSelect3};

  scc_duty_meter u_duty (
    .clk    (clk),
    .arst_n (arst_n),
    .pwmIn  (spindleCurrentCommand),
    .level  (setLevel)
  );

  // Chopping is only armed while a winding pair is energised in PWM mode
  assign oneShotFire = cur.limitHit
                     && (cur.mode == MODE_PWM)
                     && (cur.step != SEL_DISABLE)
                     && (cur.step != SEL_BRAKE)
                     && !underVoltage;

  scc_off_timer #(
    .OFF_LEN  (OFF_CYCLES),
    .LOCK_LEN (LOCKOUT_CYCLES)
  ) u_off (
    .clk        (clk),
    .arst_n     (arst_n),
    .fire       (oneShotFire),
    .offActive  (offActive),
    .lockActive ()
  );

  // Input decoder truth table
  always_comb begin
    baseDrive   = '0;
    commutating = 1'b1;
    case (selCode)
      SEL_DISABLE: begin
        baseDrive[PHASE_U] = DRV_OFF;
        baseDrive[PHASE_V] = DRV_OFF;
        baseDrive[PHASE_W] = DRV_OFF;
        commutating        = 1'b0;
      end
      SEL_BRAKE: begin
        // Braking is entered only on the controller's request
        baseDrive[PHASE_U] = DRV_HIGH;
        baseDrive[PHASE_V] = DRV_HIGH;
        baseDrive[PHASE_W] = DRV_HIGH;
        commutating        = 1'b0;
      end
      SEL_STATE1: begin
        baseDrive[PHASE_U] = DRV_LOW;
        baseDrive[PHASE_V] = DRV_OFF;
        baseDrive[PHASE_W] = DRV_HIGH;
      end
      SEL_STATE2: begin
        baseDrive[PHASE_U] = DRV_OFF;
        baseDrive[PHASE_V] = DRV_LOW;
        baseDrive[PHASE_W] = DRV_HIGH;
      end
      SEL_STATE3: begin
        baseDrive[PHASE_U] = DRV_HIGH;
        baseDrive[PHASE_V] = DRV_LOW;
        baseDrive[PHASE_W] = DRV_OFF;
      end
      SEL_STATE4: begin
        baseDrive[PHASE_U] = DRV_HIGH;
        baseDrive[PHASE_V] = DRV_OFF;
        baseDrive[PHASE_W] = DRV_LOW;
      end
      SEL_STATE5: begin
        baseDrive[PHASE_U] = DRV_OFF;
        baseDrive[PHASE_V] = DRV_HIGH;
        baseDrive[PHASE_W] = DRV_LOW;
      end
      SEL_STATE6: begin
        baseDrive[PHASE_U] = DRV_LOW;
        baseDrive[PHASE_V] = DRV_HIGH;
        baseDrive[PHASE_W] = DRV_OFF;
      end
      default: begin
        baseDrive   = '0;
        commutating = 1'b0;
      end
    endcase
  end

  // Next state of the top-level state register
  always_comb begin
    next_cur = cur;

    // Mode line decode; an unused code falls back to linear
    case (spindleModeLine)
      MODE_LINE_FULL: begin
        next_cur.mode = MODE_INDUCTION;
      end
      MODE_LINE_MID: begin
        next_cur.mode = MODE_PWM;
      end
      default: begin
        next_cur.mode = MODE_LINEAR;
      end
    endcase

    // Sampled current comparator against the set level
    next_cur.limitHit = (currentSense >= setLevel);
    next_cur.step     = selCode;

    // Lower gate handling per phase, by active mode
    for (int p = 0; p < 3; p++) begin
      next_cur.drive[p] = baseDrive[p];
      if (commutating && (baseDrive[p] == DRV_LOW)) begin
        unique case (cur.mode)
          MODE_INDUCTION: begin
            // Saturated drive, current limited by supply only
            next_cur.drive[p] = DRV_LOW;
          end
          MODE_PWM: begin
            // On again once the one-shot ends; on-time not fixed
            if (offActive || (setLevel == LEVEL_ZERO)) begin
              next_cur.drive[p] = DRV_OFF;
            end else begin
              next_cur.drive[p] = DRV_LOW;
            end
          end
          MODE_LINEAR: begin
            // Continuous regulation from the sense level, no one-shot
            if (cur.limitHit || (setLevel == LEVEL_ZERO)) begin
              next_cur.drive[p] = DRV_OFF;
            end else begin
              next_cur.drive[p] = DRV_LOW;
            end
          end
        endcase
      end
      if (underVoltage) begin
        next_cur.drive[p] = DRV_OFF;
      end
    end

    // Upper gates run resistive in linear mode while commutating
    next_cur.upperLinear = (cur.mode == MODE_LINEAR)
                         && commutating
                         && !underVoltage;

    // Comparator results back to the controller
    next_cur.senseU = bemfCompU;
    next_cur.senseV = bemfCompV;
    if (cur.mode == MODE_INDUCTION) begin
      next_cur.senseW = inductionComp;
    end else begin
      next_cur.senseW = bemfCompW;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= TOP_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Gate outputs, upper bit then lower bit of each drive code
  assign phaseUOutputHigh  = cur.drive[PHASE_U][1];
  assign phaseUOutputLow   = cur.drive[PHASE_U][0];
  assign phaseVOutputHigh  = cur.drive[PHASE_V][1];
  assign phaseVOutputLow   = cur.drive[PHASE_V][0];
  assign phaseWOutputHigh  = cur.drive[PHASE_W][1];
  assign phaseWOutputLow   = cur.drive[PHASE_W][0];

  assign bemfSenseU        = cur.senseU;
  assign bemfSenseV        = cur.senseV;
  assign bemfSenseWShared  = cur.senseW;
  assign upperLinearRegion = cur.upperLinear;
  assign offTimeActive     = offActive;
  assign currentSetLevel   = setLevel;
  assign commutationStep   = cur.step;
  assign spindleMode       = cur.mode;

endmodule : scc_spindle_ctrl

// [hdl/scc_pkg.sv]
// Shared constants and state types for the spindle commutation control block
package scc_pkg;

  // Clock and off-time timing
  localparam int CLK_PERIOD_NS      = 40;
  localparam int OFF_TIME_NS        = 10400;
  localparam int OFF_CYCLES         = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCKOUT_PERCENT    = 10;
  localparam int LOCKOUT_CYCLES_RAW = (OFF_CYCLES * LOCKOUT_PERCENT) / 100;
  localparam int LOCKOUT_CYCLES     = (LOCKOUT_CYCLES_RAW < 1) ? 1 : LOCKOUT_CYCLES_RAW;
  localparam int TIMER_W            = 9;

  // Current command duty measurement
  localparam int              LEVEL_W           = 8;
  localparam int              WIN_SPAN          = 256;
  localparam int              DUTY_ZERO_PERCENT = 5;
  localparam logic [7:0]      WIN_LAST          = 8'hFF;
  localparam logic [8:0]      DUTY_FULL         = 9'h100;
  localparam logic [8:0]      DUTY_ZERO_MAX     = 9'((WIN_SPAN * DUTY_ZERO_PERCENT) / 100);
  localparam logic [7:0]      LEVEL_MAX         = 8'hFF;
  localparam logic [7:0]      LEVEL_ZERO        = 8'h00;

  // Select codes, ordered {select1, select2, select3}
  localparam logic [2:0] SEL_DISABLE = 3'h0;
  localparam logic [2:0] SEL_BRAKE   = 3'h7;
  localparam logic [2:0] SEL_STATE1  = 3'h6;
  localparam logic [2:0] SEL_STATE2  = 3'h4;
  localparam logic [2:0] SEL_STATE3  = 3'h5;
  localparam logic [2:0] SEL_STATE4  = 3'h1;
  localparam logic [2:0] SEL_STATE5  = 3'h3;
  localparam logic [2:0] SEL_STATE6  = 3'h2;

  // Phase drive codes, ordered {upper gate, lower gate}
  localparam logic [1:0] DRV_OFF  = 2'h0;
  localparam logic [1:0] DRV_LOW  = 2'h1;
  localparam logic [1:0] DRV_HIGH = 2'h2;
  localparam int         PHASE_U  = 0;
  localparam int         PHASE_V  = 1;
  localparam int         PHASE_W  = 2;

  // Three-level mode line, encoded by the level translator
  localparam logic [1:0] MODE_LINE_GND  = 2'h0;
  localparam logic [1:0] MODE_LINE_MID  = 2'h1;
  localparam logic [1:0] MODE_LINE_FULL = 2'h2;

  typedef enum logic [2:0] {
    MODE_INDUCTION = 3'h1,
    MODE_PWM       = 3'h2,
    MODE_LINEAR    = 3'h4
  } scc_mode_t;

  typedef struct packed {
    logic               offActive;
    logic               lockActive;
    logic [TIMER_W-1:0] count;
  } scc_timer_state_t;

  typedef struct packed {
    logic [7:0]         winCnt;
    logic [8:0]         highCnt;
    logic [LEVEL_W-1:0] level;
  } scc_duty_state_t;

  typedef struct packed {
    scc_mode_t          mode;
    logic [2:0][1:0]    drive;
    logic [2:0]         step;
    logic               senseU;
    logic               senseV;
    logic               senseW;
    logic               upperLinear;
    logic               limitHit;
  } scc_top_state_t;

endpackage : scc_pkg

// [hdl/scc_duty_meter.sv]
// Measures the current-command PWM duty and yields the current set level
`timescale 1ns/10ps
module scc_duty_meter
  import scc_pkg::*;
(
  input  wire logic               clk,      // 25 MHz clock
  input  wire logic               arst_n,   // Async reset, active low
  input  wire logic               pwmIn,    // Current-command PWM
  output logic [LEVEL_W-1:0]      level     // Set level, updated per window
);

  scc_duty_state_t cur;
  scc_duty_state_t next_cur;
  logic [8:0]      next_high;

  always_comb begin
    next_cur  = cur;
    next_high = cur.highCnt + {8'h00, pwmIn};
    next_cur.winCnt = cur.winCnt + 8'h01;
    if (cur.winCnt == WIN_LAST) begin
      // Only the duty factor counts, never the logic level itself
      if (next_high >= DUTY_FULL) begin
        next_cur.level = LEVEL_MAX;
      end else if (next_high <= DUTY_ZERO_MAX) begin
        next_cur.level = LEVEL_ZERO;
      end else begin
        next_cur.level = next_high[LEVEL_W-1:0];
      end
      next_cur.highCnt = 9'h000;
    end else begin
      next_cur.highCnt = next_high;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.level;

endmodule : scc_duty_meter

// [hdl/scc_off_timer.sv]
// Off-time one-shot with a lockout window that sets the least on-time
`timescale 1ns/10ps
module scc_off_timer
  import scc_pkg::*;
#(
  parameter int OFF_LEN  = OFF_CYCLES,      // Off-time in clocks
  parameter int LOCK_LEN = LOCKOUT_CYCLES   // Retrigger lockout in clocks
)
(
  input  wire logic clk,        // 25 MHz clock
  input  wire logic arst_n,     // Async reset, active low
  input  wire logic fire,       // Current reached set level
  output logic      offActive,  // Lower drivers held off
  output logic      lockActive  // Triggers ignored
);

  scc_timer_state_t cur;
  scc_timer_state_t next_cur;

  always_comb begin
    next_cur = cur;
    if (cur.offActive) begin
      if (cur.count == TIMER_W'(1)) begin
        next_cur.offActive  = 1'b0;
        next_cur.lockActive = 1'b1;
        next_cur.count      = TIMER_W'(LOCK_LEN);
      end else begin
        next_cur.count = cur.count - TIMER_W'(1);
      end
    end else if (cur.lockActive) begin
      // A trigger here is dropped, so the drivers stay on
      if (cur.count == TIMER_W'(1)) begin
        next_cur.lockActive = 1'b0;
        next_cur.count      = '0;
      end else begin
        next_cur.count = cur.count - TIMER_W'(1);
      end
    end else if (fire) begin
      next_cur.offActive = 1'b1;
      next_cur.count     = TIMER_W'(OFF_LEN);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign offActive  = cur.offActive;
  assign lockActive = cur.lockActive;

endmodule : scc_off_timer

// [verification/scc_spindle_ctrl_asserts.sv]
// Assertion checker for the spindle commutation control top
`timescale 1ns/10ps
module scc_spindle_ctrl_asserts
  import scc_pkg::*;
(
  input wire logic       clk,              // Clock
  input wire logic       arst_n,           // Reset
  input wire logic       phaseSelect1,     // Select 1
  input wire logic       phaseSelect2,     // Select 2
  input wire logic       phaseSelect3,     // Select 3
  input wire logic [1:0] spindleModeLine,  // Mode line
  input wire logic       underVoltage,     // Low supply
  input wire logic       inductionComp,    // Induction comparator
  input wire logic       phaseUOutputHigh, // U upper
  input wire logic       phaseUOutputLow,  // U lower
  input wire logic       phaseVOutputHigh, // V upper
  input wire logic       phaseVOutputLow,  // V lower
  input wire logic       phaseWOutputHigh, // W upper
  input wire logic       phaseWOutputLow,  // W lower
  input wire logic       bemfSenseWShared, // Shared sense
  input wire logic       offTimeActive,    // One-shot
  input wire logic [2:0] spindleMode       // Active mode
);
  // Upper and lower gate sets {U,V,W} per select code
  localparam logic [7:0][2:0] HI_MAP = 24'hE614A0;
  localparam logic [7:0][2:0] LO_MAP = 24'h112308;
  logic [2:0] sel;
  logic [2:0] uppers;
  logic [2:0] lowers;
  logic [8:0] onRun;
  logic [8:0] lowRun;
  assign sel    = {phaseSelect1, phaseSelect2, phaseSelect3};
  assign uppers = {phaseUOutputHigh, phaseVOutputHigh, phaseWOutputHigh};
  assign lowers = {phaseUOutputLow, phaseVOutputLow, phaseWOutputLow};
  // Lengths of the current high and low runs of the one-shot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      onRun  <= 9'h000;
      lowRun <= 9'h1FF;
    end else begin
      onRun  <= offTimeActive ? onRun + 9'h001 : 9'h000;
      lowRun <= offTimeActive ? 9'h000 : ((lowRun == 9'h1FF) ? lowRun : lowRun + 9'h001);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  dis_off_a: assert property (sel == SEL_DISABLE |=> {uppers, lowers} == 6'h00)
    else $error("phase driven while disabled");
  uv_off_a: assert property (underVoltage |=> {uppers, lowers} == 6'h00)
    else $error("phase driven in undervoltage");
  brake_all_a: assert property (sel == SEL_BRAKE && !underVoltage
    |=> uppers == 3'h7 && lowers == 3'h0)
    else $error("braking pattern wrong");
  upper_map_a: assert property (!underVoltage |=> uppers == HI_MAP[$past(sel)])
    else $error("upper gates differ from decode");
  lower_set_a: assert property (1'b1 |=> (lowers & ~LO_MAP[$past(sel)]) == 3'h0)
    else $error("lower gate on for wrong phase");
  ind_lower_a: assert property (spindleMode == MODE_INDUCTION && !underVoltage
    |=> lowers == LO_MAP[$past(sel)])
    else $error("induction lower gates not saturated");
  pwm_off_a: assert property (spindleMode == MODE_PWM && offTimeActive |=> lowers == 3'h0)
    else $error("lower gate on during off-time");
  ind_share_a: assert property (spindleModeLine == MODE_LINE_FULL [*2]
    |=> bemfSenseWShared == $past(inductionComp))
    else $error("shared sense not induction");
  mode_mid_a: assert property (spindleModeLine == MODE_LINE_MID
    |=> spindleMode == MODE_PWM)
    else $error("mid level not PWM mode");
  off_len_a: assert property ($fell(offTimeActive) |-> onRun == 9'(OFF_CYCLES))
    else $error("off-time length wrong");
  lock_gap_a: assert property ($rose(offTimeActive) |-> lowRun >= 9'(LOCKOUT_CYCLES))
    else $error("retrigger inside lockout");
  brake_c: cover property (sel == SEL_BRAKE);
  chop_c: cover property ($rose(offTimeActive));
  ind_c: cover property (spindleMode == MODE_INDUCTION && inductionComp);
endmodule : scc_spindle_ctrl_asserts

bind scc_spindle_ctrl scc_spindle_ctrl_asserts chk (.*);

// [verification/scc_ctrl_model.sv]
// Behavioural model of the external spindle controller and coil current
`timescale 1ns/10ps
module scc_ctrl_model
  import scc_pkg::*;
(
  input  wire logic       clk,       // Clock
  input  wire logic       arst_n,    // Reset
  input  wire logic [8:0] duty,      // High clocks per 256
  input  wire logic [2:0] selCmd,    // Wanted code
  input  wire logic       powerDown, // Power-down
  input  wire logic       lowerOn,   // A lower gate on
  output logic      [2:0] sel,       // Select lines
  output logic            pwmOut,    // Current command
  output logic      [7:0] coil       // Sensed current
);
  logic [7:0] phase;
  // Braking is never requested while power-down is in progress
  assign sel    = (selCmd == SEL_BRAKE && powerDown) ? SEL_DISABLE : selCmd;
  assign pwmOut = {1'b0, phase} < duty;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 8'h00;
      coil  <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
      // Fast rise keeps the lockout window in play between off periods
      if (lowerOn)
        coil <= (coil > 8'hEF) ? 8'hFF : coil + 8'h10;
      else if (coil != 8'h00)
        coil <= coil - 8'h01;
    end
  end
endmodule : scc_ctrl_model

// [verification/test_scc_spindle_ctrl.sv]
// Self-checking testbench for the spindle commutation control block
`timescale 1ns/10ps
module test_scc_spindle_ctrl
  import scc_pkg::*;
;
  typedef struct packed {
    int          due;
    logic [2:0]  kind;
    logic [15:0] exp;
    logic [15:0] msk;
  } scc_note_t;
  // Gate words {UH,UL,VH,VL,WH,WL} per select code
  localparam logic [7:0][7:0] GATE_MAP = 64'h2A12240609182100;
  localparam logic [3:0][2:0] MODE_MAP = {MODE_LINEAR, MODE_INDUCTION, MODE_PWM, MODE_LINEAR};
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] selCmd = 3'h0;
  logic [8:0] duty = 9'h000;
  logic [1:0] spindleModeLine = 2'h0;
  logic       underVoltage = 1'b0;
  logic       bemfCompU = 1'b0;
  logic       bemfCompV = 1'b0;
  logic       bemfCompW = 1'b0;
  logic       inductionComp = 1'b0;
  logic       powerDown = 1'b0;
  wire logic  phaseSelect1, phaseSelect2, phaseSelect3, spindleCurrentCommand, lowerOn;
  wire logic  phaseUOutputHigh, phaseUOutputLow, phaseVOutputHigh, phaseVOutputLow;
  wire logic  phaseWOutputHigh, phaseWOutputLow, bemfSenseU, bemfSenseV, bemfSenseWShared;
  wire logic  upperLinearRegion, offTimeActive;
  wire logic [7:0] currentSense, currentSetLevel;
  wire logic [2:0] sel, commutationStep, spindleMode;
  wire logic [5:0] gates;
  int         cyc = 0;
  int         nMismatch = 0;
  int         numChecks = 0;
  int         n, m;
  int         dutyList[4];
  scc_note_t  cur;
  scc_note_t  notes[$];
  assign {phaseSelect1, phaseSelect2, phaseSelect3} = sel;
  assign gates = {phaseUOutputHigh, phaseUOutputLow, phaseVOutputHigh, phaseVOutputLow,
                  phaseWOutputHigh, phaseWOutputLow};
  assign lowerOn = phaseUOutputLow | phaseVOutputLow | phaseWOutputLow;
  scc_spindle_ctrl uut (.*);
  scc_ctrl_model partner (
    .clk       (clk),
    .arst_n    (arst_n),
    .duty      (duty),
    .selCmd    (selCmd),
    .powerDown (powerDown),
    .lowerOn   (lowerOn),
    .sel       (sel),
    .pwmOut    (spindleCurrentCommand),
    .coil      (currentSense)
  );
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(posedge clk) cyc++;
  function automatic logic [15:0] obs(input logic [2:0] k);
    case (k)
      3'h0: return 16'(gates);
      3'h1: return 16'(currentSetLevel);
      3'h2: return 16'({bemfSenseU, bemfSenseV, bemfSenseWShared});
      3'h3: return 16'(spindleMode);
      3'h4: return 16'(upperLinearRegion);
      default: return 16'(commutationStep);
    endcase
  endfunction : obs
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic note(input logic [2:0] k, input logic [15:0] e, input logic [15:0] msk);
    notes.push_back('{cyc + 1, k, e, msk});
  endtask : note
  task automatic step(input int cnt);
    repeat (cnt) @(negedge clk);
  endtask : step
  task automatic waitOff(input logic want, input int lim, output int cnt);
    cnt = 0;
    while (offTimeActive !== want && cnt < lim) begin
      step(1);
      cnt++;
    end
  endtask : waitOff
  task summarize;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // Result watcher: compares each due note with the settled outputs
  always @(negedge clk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      cur = notes.pop_front();
      check(obs(cur.kind) & cur.msk, cur.exp & cur.msk);
    end
  end
  initial begin
    #(CLK_PERIOD_NS * 8000);
    nMismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'h2522));
    step(10);
    arst_n = 1'b1;
    for (int l = 0; l < 4; l++) begin
      spindleModeLine = 2'(l);
      note(3'h3, 16'(MODE_MAP[l]), 16'h0007);
      step(1);
    end
    spindleModeLine = MODE_LINE_FULL;
    step(2);
    for (int c = 0; c < 8; c++) begin
      selCmd = 3'(c);
      note(3'h0, 16'(GATE_MAP[c][5:0]), 16'h003F);
      note(3'h5, 16'(c), 16'h0007);
      step(1);
    end
    selCmd = 3'($urandom_range(6, 1));
    underVoltage = 1'b1;
    note(3'h0, 16'h0000, 16'h003F);
    step(1);
    underVoltage = 1'b0;
    for (int p = 0; p < 2; p++) begin
      spindleModeLine = p ? MODE_LINE_GND : MODE_LINE_FULL;
      step(3);
      for (int i = 0; i < 12; i++) begin
        {bemfCompU, bemfCompV, bemfCompW, inductionComp} = 4'($urandom);
        selCmd = 3'($urandom_range(6, 1));
        note(3'h2, 16'({bemfCompU, bemfCompV, p ? bemfCompW : inductionComp}), 16'h0007);
        // Zero set level in linear mode keeps every lower gate off
        note(3'h0, 16'(GATE_MAP[selCmd][5:0] & (p ? 6'h2A : 6'h3F)), 16'h003F);
        if (p)
          note(3'h4, 16'h0001, 16'h0001);
        step(1);
      end
    end
    selCmd = SEL_DISABLE;
    dutyList = '{256, 12, 13, $urandom_range(255, 14)};
    for (int i = 0; i < 4; i++) begin
      duty = 9'(dutyList[i]);
      step(520);
      note(3'h1, (dutyList[i] == 256) ? 16'h00FF : ((dutyList[i] <= DUTY_ZERO_MAX) ? 16'h0000
           : 16'(dutyList[i])), 16'h00FF);
      step(1);
    end
    duty = 9'h080;
    step(520);
    spindleModeLine = MODE_LINE_MID;
    selCmd = SEL_STATE1;
    waitOff(1'b1, 100, n);
    check(16'(offTimeActive), 16'h0001);
    waitOff(1'b0, 400, n);
    check(16'(n), 16'(OFF_CYCLES));
    waitOff(1'b1, 100, m);
    check(16'(m >= LOCKOUT_CYCLES && m <= LOCKOUT_CYCLES + 3), 16'h0001);
    step(2);
    arst_n = 1'b0;
    step(1);
    check(obs(3'h0), 16'h0000);
    check(obs(3'h3), 16'(MODE_LINEAR));
    arst_n = 1'b1;
    step(2);
    summarize();
  end
endmodule : test_scc_spindle_ctrl
